// file: verification/id_rom_model.sv
// Behavioural identification ROM device that answers on the single line.
`timescale 1ns/100ps
`default_nettype none
`include "line_master_map.vh"

module id_rom_model #(
   parameter [63:0] ROM       = 64'h0,
   parameter        RST_MIN   = 800,
   parameter        PRES_WAIT = 200,
   parameter        PRES_LOW  = 600,
   parameter        SAMP      = 300
)(
   input  wire logic clk,
   input  wire logic line,
   output var  logic pull
);
   logic       prev_r = 1'b1;
   logic [7:0] cmd_r  = 8'h00;
   int         low_r  = 0;
   int         pc_r   = -1;
   int         sc_r   = -1;
   int         bit_r  = 0;
   int         ph_r   = 0;
   int         mode_r = 0;
   wire  [7:0] nc     = {line, cmd_r[7:1]};
   // Bit for a read slot: ROM bit, or its inverse in the second search step.
   wire        tx = (mode_r == 3 && ph_r == 1) ? ~ROM[bit_r] : ROM[bit_r];
   initial pull = 1'b0;

   // Watches the line: reset, presence, then slots timed from each fall.
   always @(posedge clk)
   begin
      prev_r <= line;
      low_r <= line ? 0 : low_r + 1;
      if (pc_r >= 0)
      begin
         pc_r <= (pc_r == PRES_WAIT + PRES_LOW) ? -1 : pc_r + 1;
         // Presence pull in the wait-then-low window.
         pull <= pc_r >= PRES_WAIT && pc_r < PRES_WAIT + PRES_LOW;
      end
      else if (line && !prev_r && low_r >= RST_MIN)
      begin
         pc_r <= 0;
         mode_r <= 1;
         bit_r <= 0;
         ph_r <= 0;
         sc_r <= -1;
      end
      else if (!line && prev_r)
      begin
         sc_r <= 1;
         // Reads and the two search reads pull for a zero.
         pull <= (mode_r == 2 || (mode_r == 3 && ph_r < 2)) && !tx;
      end
      else if (sc_r == SAMP)
      begin
         sc_r <= -1;
         pull <= 1'b0;
         if (mode_r == 1)
         begin
            cmd_r <= nc;
            bit_r <= (bit_r + 1) % 8;
            if (bit_r == 7)
               mode_r <= (nc == `ROM_CMD_READ_A ||
                          nc == `ROM_CMD_READ_B) ? 2 :
                         (nc == `ROM_CMD_SEARCH) ? 3 : 0;
         end
         else if (mode_r == 2)
         begin
            bit_r <= bit_r + 1;
            if (bit_r == 63)
               mode_r <= 0;
         end
         else if (mode_r == 3)
         begin
            ph_r <= (ph_r + 1) % 3;
            if (ph_r == 2)
               bit_r <= bit_r + 1;
            if (ph_r == 2 && (line != ROM[bit_r] || bit_r == 63))
               mode_r <= 0;
         end
      end
      else if (sc_r >= 0)
         sc_r <= sc_r + 1;
   end
endmodule
`default_nettype wire

// file: verification/line_master_sva.sv
// Concurrent checks on the ports of the line master.
`timescale 1ns/100ps
`default_nettype none
`include "line_master_map.vh"

module line_master_sva #(
   parameter [`CNT_W-1:0] RESET_LOW_CYCLES = `RESET_LOW_CYC,
   parameter [`CNT_W-1:0] RESET_REC_CYCLES = `RESET_REC_CYC
)(
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               ce,
   input wire logic               cmd_valid,
   input wire logic               cmd_ready,
   input wire logic [1:0]         cmd_op,
   input wire logic [`DATA_W-1:0] cmd_data,
   input wire logic               cmd_dir,
   input wire logic               rsp_valid,
   input wire logic               rsp_ready,
   input wire logic [`DATA_W-1:0] rsp_data,
   input wire logic               busy,
   input wire logic               line_in,
   input wire logic               line_out,
   input wire logic               line_oe_n
);
   logic [1:0]  op_r;
   logic [13:0] run_r;
   logic [11:0] gap_r;
   logic [3:0]  falls_r;
   wire         take = cmd_valid && cmd_ready;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Track the operation, the low run, the slot spacing and slot count.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         op_r <= `OP_RESET;
         run_r <= 14'h0000;
         gap_r <= 12'hfff;
         falls_r <= 4'h0;
      end
      else if (ce)
      begin
         if (take)
            op_r <= cmd_op;
         run_r <= line_oe_n ? 14'h0000 : run_r + 14'h0001;
         if ($fell(line_oe_n))
            gap_r <= 12'h000;
         else if (gap_r != 12'hfff)
            gap_r <= gap_r + 12'h001;
         if (take)
            falls_r <= 4'h0;
         else if ($fell(line_oe_n))
            falls_r <= falls_r + 4'h1;
      end
   end

   sequence reset_pulse_end;
      $rose(line_oe_n) && op_r == `OP_RESET;
   endsequence
   sequence slot_start;
      $fell(line_oe_n);
   endsequence

   chk_line_out_zero: assert property (line_out == 1'b0)
      else $error("line driven high");
   chk_idle_released: assert property (!busy |-> line_oe_n)
      else $error("line pulled while idle");
   chk_take_starts: assert property (take |=> busy && !cmd_ready)
      else $error("taken command did not start");
   chk_reset_len: assert property (reset_pulse_end |->
      run_r == RESET_LOW_CYCLES) else $error("reset pulse length wrong");
   chk_listen_after: assert property (reset_pulse_end |->
      line_oe_n[*8]) else $error("line pulled during presence wait");
   chk_slot_spacing: assert property (slot_start |->
      gap_r >= 12'h265) else $error("slots too close");
   chk_slot_count: assert property ($fell(busy) |-> falls_r ==
      (op_r == `OP_TRIPLET ? 4'h3 : op_r == `OP_RESET ? 4'h1 : 4'h8))
      else $error("wrong number of slots");
   chk_read_short: assert property ($rose(line_oe_n) &&
      op_r == `OP_READ |-> run_r < 14'h0082)
      else $error("read slot low too long");
endmodule

bind line_master line_master_sva #(
   .RESET_LOW_CYCLES (RESET_LOW_CYCLES),
   .RESET_REC_CYCLES (RESET_REC_CYCLES)
) u_line_master_sva (
   .clk       (clk),
   .rst_n     (rst_n),
   .ce        (ce),
   .cmd_valid (cmd_valid),
   .cmd_ready (cmd_ready),
   .cmd_op    (cmd_op),
   .cmd_data  (cmd_data),
   .cmd_dir   (cmd_dir),
   .rsp_valid (rsp_valid),
   .rsp_ready (rsp_ready),
   .rsp_data  (rsp_data),
   .busy      (busy),
   .line_in   (line_in),
   .line_out  (line_out),
   .line_oe_n (line_oe_n)
);
`default_nettype wire

// file: verification/line_master_tb.sv
// Self-checking bench: line master against two behavioural ROM devices.
`timescale 1ns/100ps
`default_nettype none
`include "line_master_map.vh"

module line_master_tb;
   // Family codes 5a and 59 are arbitrary; the two codes differ in bits 0, 1.
   localparam [63:0] ROM_A = 64'hc3_0123456789ab_5a;
   localparam [63:0] ROM_B = 64'h96_0a1b2c3d4e5f_59;
   localparam [23:0] CODES = {`ROM_CMD_READ_B, `ROM_CMD_MATCH, `ROM_CMD_SKIP};
   localparam        LIM   = 12000;
   logic       clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cmd_valid = 1'b0;
   logic       cmd_dir = 1'b0, rsp_ready = 1'b0, en_a = 1'b1, en_b = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [7:0] cmd_data = 8'h00;
   wire        cmd_ready, rsp_valid, busy, line_out, line_oe_n;
   wire        pull_a, pull_b;
   wire  [7:0] rsp_data;
   // Open-drain line with pull-up: low when any enabled party pulls.
   wire        line = (line_oe_n | line_out) & ~(pull_a & en_a) &
                      ~(pull_b & en_b);
   int         failures = 0;
   int         comparisons = 0;

   always #50 clk = ~clk;

   // Short reset times keep the run brief; recovery still ends after presence.
   line_master #(.RESET_LOW_CYCLES (13'h2bc), .RESET_REC_CYCLES (13'h352))
   u_line_master (.clk (clk), .rst_n (rst_n), .ce (ce),
      .cmd_valid (cmd_valid), .cmd_ready (cmd_ready), .cmd_op (cmd_op),
      .cmd_data (cmd_data), .cmd_dir (cmd_dir), .rsp_valid (rsp_valid),
      .rsp_ready (rsp_ready), .rsp_data (rsp_data), .busy (busy),
      .line_in (line), .line_out (line_out), .line_oe_n (line_oe_n));
   // A low run of 650 cycles is a reset: above a write zero, below the pulse.
   id_rom_model #(.ROM (ROM_A), .RST_MIN (650)) u_id_rom_model_a (.clk (clk),
      .line (line), .pull (pull_a));
   id_rom_model #(.ROM (ROM_B), .RST_MIN (650)) u_id_rom_model_b (.clk (clk),
      .line (line), .pull (pull_b));

   // Prints the verdict and ends the run.
   task automatic print_verdict;
   begin
      if (failures == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   task automatic bad(input string msg);
   begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
   end
   endtask

   // Presents one command, holds it until taken, waits until idle again.
   task automatic run_op(input logic [1:0] op, input logic [7:0] d,
                         input logic dir);
      int n;
   begin
      n = 0;
      @(negedge clk);
      cmd_op = op;
      cmd_data = d;
      cmd_dir = dir;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && n < LIM)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      while (busy !== 1'b0 && n < LIM)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= LIM)
      begin
         bad("operation hung");
         print_verdict();
      end
   end
   endtask

   // Takes the head word and compares the masked bits.
   task automatic pop(input logic [7:0] exp, input logic [7:0] mask);
   begin
      comparisons++;
      if (rsp_valid !== 1'b1)
      begin
         bad("no response word");
         print_verdict();
      end
      if ((rsp_data & mask) !== exp)
         bad("response word differs");
      rsp_ready = 1'b1;
      @(negedge clk);
      rsp_ready = 1'b0;
      // Let an edge pass so a following pop does not raise ready at once.
      @(negedge clk);
   end
   endtask

   // Freeze, then fill the buffer with presence words; the last is absent.
   task automatic t_fifo;
      int i;
   begin
      ce = 1'b0;
      @(negedge clk);
      comparisons++;
      if (cmd_ready !== 1'b0)
         bad("ready while frozen");
      ce = 1'b1;
      for (i = 0; i < 4; i++)
      begin
         en_a = (i < 3);
         run_op(`OP_RESET, 8'h00, 1'b0);
      end
      en_a = 1'b1;
      comparisons++;
      if (cmd_ready !== 1'b0)
         bad("ready with full buffer");
      for (i = 0; i < 4; i++)
         pop({1'b1, 6'h00, i < 3}, 8'h81);
      comparisons++;
      if (rsp_valid !== 1'b0)
         bad("buffer not empty");
   end
   endtask

   // Full code read, then a probe showing the device has gone quiet.
   task automatic t_read;
      int i;
   begin
      run_op(`OP_RESET, 8'h00, 1'b0);
      pop(8'h01, 8'h01);
      run_op(`OP_WRITE, `ROM_CMD_READ_A, 1'b0);
      for (i = 0; i < 8; i++)
      begin
         run_op(`OP_READ, 8'h00, 1'b0);
         pop(ROM_A[i*8 +: 8], 8'hff);
      end
      run_op(`OP_TRIPLET, 8'h00, 1'b0);
      pop(8'h03, 8'h07);
   end
   endtask

   // Second read code answers; match and skip leave the line released.
   task automatic t_codes;
      int i;
   begin
      for (i = 0; i < 3; i++)
      begin
         run_op(`OP_RESET, 8'h00, 1'b0);
         pop(8'h01, 8'h01);
         run_op(`OP_WRITE, CODES[i*8 +: 8], 1'b0);
         run_op(`OP_TRIPLET, 8'h00, 1'b1);
         pop(i == 2 ? {5'h00, ROM_A[0] != ROM_A[1] ? ROM_A[0] : 1'b1,
             ROM_A[1], ROM_A[0]} : 8'h07, 8'h07);
      end
   end
   endtask

   // Two devices collide on bit 0; direction one leaves only the second.
   task automatic t_search;
   begin
      en_b = 1'b1;
      run_op(`OP_RESET, 8'h00, 1'b0);
      pop(8'h01, 8'h01);
      run_op(`OP_WRITE, `ROM_CMD_SEARCH, 1'b0);
      run_op(`OP_TRIPLET, 8'h00, 1'b1);
      pop({5'h00, 1'b1, ~(ROM_A[0] | ROM_B[0]), ROM_A[0] & ROM_B[0]},
          8'h07);
      run_op(`OP_TRIPLET, 8'h00, 1'b1);
      pop({5'h00, ROM_B[1], ~ROM_B[1], ROM_B[1]}, 8'h07);
      en_b = 1'b0;
   end
   endtask

   // Reset for three cycles, then the scenarios in turn.
   initial
   begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_fifo();
      t_read();
      t_codes();
      t_search();
      print_verdict();
   end
endmodule
`default_nettype wire

// file: verilog/line_master.v
// Single-line open-drain bus master with command port and response FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "line_master_map.vh"

// Notes on behaviour
// R01: Slave holds family code, 48-bit serial and check code, read here.
// R02: Every byte goes and comes least significant bit first.
// R03: Every slot starts with this master pulling the line low.
// R04: The line is only pulled low or released; pull-up gives high.
// R05: Idle leaves line released high; never low beyond the slot.
// R06: Slots last 75 us so the bit rate stays below 16.3k.
// R07: Transactions open with reset pulse and presence detection.
// R08: Reset pulse holds the line low at least 480 us.
// R09: After reset the line is released and presence is sampled.
// R10: Slave waits 15-60 us then pulls low for 60-240 us.
// R11: Only this master starts reset, write and read slots.
// R12: Command bytes are sent as exactly eight write slots.
// R13: Read commands 33h or 0Fh return the 64-bit code.
// R14: User issues read-code command only with a single slave attached.
// R15: Match and skip commands cause no reply from the slave.
// R16: Search step: read bit, read complement, write chosen bit.
// R17: Slave samples write slots after its own delay from the edge.
// R18: Slave holds the line low in a read slot carrying zero.
// R19: Slave leaves the line released in a read slot carrying one.
// R20: Reset low plus rise time stays under 960 us.
// R21: Slave drops out of search when the written bit differs.
// R22: Slave goes quiet after unknown commands or full transfers.
// R23: Slave samples write slots 15 to 60 us after the edge.

// ----------------------------------------------------------------------
// Response FIFO
// ----------------------------------------------------------------------
module resp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
)(
   input  wire             clk,
   input  wire             rst_n,
   input  wire             ce,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   reg [AW:0]      count_r;
   wire            push;
   wire            pop;

   // Full and empty come straight from the word count.
   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_r];
   assign push      = ce & in_valid & in_ready;
   assign pop       = ce & out_valid & out_ready;

   // Storage array; written only on an accepted push.
   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // Pointers and count, frozen while ce is low.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push & ~pop)
         begin
            count_r <= count_r + 1'b1;
         end
         else if (pop & ~push)
         begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

// ----------------------------------------------------------------------
// Line master
// ----------------------------------------------------------------------
module line_master #(
   parameter [`CNT_W-1:0] RESET_LOW_CYCLES = `RESET_LOW_CYC,
   parameter [`CNT_W-1:0] RESET_REC_CYCLES = `RESET_REC_CYC
)(
   input  wire               clk,
   input  wire               rst_n,
   input  wire               ce,
   input  wire               cmd_valid,
   output wire               cmd_ready,
   input  wire [1:0]         cmd_op,
   input  wire [`DATA_W-1:0] cmd_data,
   input  wire               cmd_dir,
   output wire               rsp_valid,
   input  wire               rsp_ready,
   output wire [`DATA_W-1:0] rsp_data,
   output wire               busy,
   input  wire               line_in,
   output wire               line_out,
   output wire               line_oe_n
);

   localparam [4:0] ST_IDLE    = 5'h01;
   localparam [4:0] ST_RST_LOW = 5'h02;
   localparam [4:0] ST_RST_WT  = 5'h04;
   localparam [4:0] ST_SLOT    = 5'h08;
   localparam [4:0] ST_FINISH  = 5'h10;

   localparam [`CNT_W-1:0] PRES_SAMPLE = `PRESENCE_SAMPLE_CYC;
   localparam [`CNT_W-1:0] LOW0_CYC    = `SLOT_LOW0_CYC;
   localparam [`CNT_W-1:0] LOW1_CYC    = `SLOT_LOW1_CYC;
   localparam [`CNT_W-1:0] SAMPLE_CYC  = `SLOT_SAMPLE_CYC;
   localparam [`CNT_W-1:0] SLOT_CYC    = `SLOT_TOTAL_CYC;

   reg [4:0]         state_r;
   reg [`CNT_W-1:0]  cnt_r;
   reg [1:0]         op_r;
   reg [`DATA_W-1:0] shreg_r;
   reg [`DATA_W-1:0] res_r;
   reg [2:0]         bitn_r;
   reg [1:0]         step_r;
   reg               drive_r;
   reg               slot_one_r;
   reg               samp_r;
   reg               id_r;
   reg               cmp_r;
   reg               dir_r;
   reg               rose_r;
   wire              fifo_in_ready;
   wire              fifo_push;
   wire              last_bit;
   wire              dir_pick;
   wire [`CNT_W-1:0] low_cyc;

   // The line is only ever pulled low; release lets the pull-up win. [R04]
   assign line_out  = 1'b0;
   assign line_oe_n = ~drive_r;   // [R04] [R05]

   // A command is taken only when a response word is sure to fit.
   assign cmd_ready = ce & (state_r == ST_IDLE) & fifo_in_ready;
   assign busy      = (state_r != ST_IDLE);
   assign fifo_push = (state_r == ST_FINISH) & (op_r != `OP_WRITE);
   assign last_bit  = (bitn_r == 3'h7);

   // Low time of the current slot: long for a zero write, else short.
   assign low_cyc   = slot_one_r ? LOW1_CYC : LOW0_CYC;

   // Search direction: take the slave's bit when it is unambiguous.
   assign dir_pick  = (samp_r != id_r) ? id_r : dir_r;   // [R16] [R21]

   // Sequencer for reset, write, read and search slots.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r    <= ST_IDLE;
         cnt_r      <= {`CNT_W{1'b0}};
         op_r       <= `OP_RESET;
         shreg_r    <= 8'h00;
         res_r      <= 8'h00;
         bitn_r     <= 3'h0;
         step_r     <= 2'h0;
         drive_r    <= 1'b0;
         slot_one_r <= 1'b1;
         samp_r     <= 1'b1;
         id_r       <= 1'b0;
         cmp_r      <= 1'b0;
         dir_r      <= 1'b0;
         rose_r     <= 1'b0;
      end
      else if (ce)
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (cmd_valid && fifo_in_ready)
               begin
                  op_r    <= cmd_op;
                  shreg_r <= cmd_data;
                  dir_r   <= cmd_dir;
                  cnt_r   <= {`CNT_W{1'b0}};
                  bitn_r  <= 3'h0;
                  step_r  <= 2'h0;
                  rose_r  <= 1'b0;
                  drive_r <= 1'b1;   // [R03] [R11]
                  if (cmd_op == `OP_RESET)
                  begin
                     state_r <= ST_RST_LOW;   // [R07]
                  end
                  else
                  begin
                     state_r    <= ST_SLOT;
                     // LSB of a write byte goes first. [R02] [R12]
                     slot_one_r <= (cmd_op == `OP_WRITE) ? cmd_data[0]
                                                         : 1'b1;
                  end
               end
            end
            ST_RST_LOW:
            begin
               cnt_r <= cnt_r + 1'b1;
               // Released at 480 us, well before 960 us. [R08] [R20]
               if (cnt_r == RESET_LOW_CYCLES - 1'b1)
               begin
                  drive_r <= 1'b0;   // [R09]
                  cnt_r   <= {`CNT_W{1'b0}};
                  state_r <= ST_RST_WT;
               end
            end
            ST_RST_WT:
            begin
               cnt_r <= cnt_r + 1'b1;
               // Line must rise after release, before presence starts.
               if ((cnt_r < PRES_SAMPLE) && line_in)
               begin
                  rose_r <= 1'b1;
               end
               // Presence shows as the line held low by a slave. [R10]
               if (cnt_r == PRES_SAMPLE)
               begin
                  res_r <= {rose_r, 6'h00, ~line_in};   // [R09]
               end
               if (cnt_r == RESET_REC_CYCLES - 1'b1)
               begin
                  state_r <= ST_FINISH;
               end
            end
            ST_SLOT:
            begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == low_cyc - 1'b1)
               begin
                  drive_r <= 1'b0;
               end
               // Read sample before the slave's zero hold ends. [R18] [R19]
               if (cnt_r == SAMPLE_CYC)
               begin
                  samp_r <= line_in;
               end
               // Slot plus recovery bounds the bit rate. [R06]
               if (cnt_r == SLOT_CYC - 1'b1)
               begin
                  cnt_r <= {`CNT_W{1'b0}};
                  case (op_r)
                     `OP_WRITE:
                     begin
                        // Slot outlasts the slave's sample point. [R17] [R23]
                        shreg_r <= {1'b0, shreg_r[7:1]};   // [R02]
                        if (last_bit)
                        begin
                           state_r <= ST_FINISH;
                        end
                        else
                        begin
                           bitn_r     <= bitn_r + 1'b1;
                           drive_r    <= 1'b1;
                           slot_one_r <= shreg_r[1];
                        end
                     end
                     `OP_READ:
                     begin
                        // First bit received ends at bit 0. [R02] [R13] [R14]
                        shreg_r <= {samp_r, shreg_r[7:1]};
                        if (last_bit)
                        begin
                           res_r   <= {samp_r, shreg_r[7:1]};
                           state_r <= ST_FINISH;
                        end
                        else
                        begin
                           bitn_r     <= bitn_r + 1'b1;
                           drive_r    <= 1'b1;
                           slot_one_r <= 1'b1;
                        end
                     end
                     `OP_TRIPLET:
                     begin
                        // Read bit, read complement, write choice. [R16]
                        if (step_r == 2'h0)
                        begin
                           id_r       <= samp_r;
                           step_r     <= 2'h1;
                           drive_r    <= 1'b1;
                           slot_one_r <= 1'b1;
                        end
                        else if (step_r == 2'h1)
                        begin
                           cmp_r      <= samp_r;
                           dir_r      <= dir_pick;
                           step_r     <= 2'h2;
                           drive_r    <= 1'b1;
                           slot_one_r <= dir_pick;
                        end
                        else
                        begin
                           res_r   <= {5'h00, dir_r, cmp_r, id_r};
                           state_r <= ST_FINISH;
                        end
                     end
                     default:
                     begin
                        state_r <= ST_FINISH;
                     end
                  endcase
               end
            end
            ST_FINISH:
            begin
               // Line is released; idle level is high. [R05]
               state_r <= ST_IDLE;
            end
            default:
            begin
               state_r <= ST_IDLE;
               drive_r <= 1'b0;
            end
         endcase
      end
   end

   // Results wait here; a full FIFO holds off new commands.
   resp_fifo #(
      .WIDTH (`DATA_W),
      .DEPTH (`RSP_FIFO_DEPTH),
      .AW    (2)
   ) u_resp_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (res_r),
      .out_valid (rsp_valid),
      .out_ready (rsp_ready),
      .out_data  (rsp_data)
   );

endmodule

`default_nettype wire

// file: verilog/line_master_map.vh
// Timing figures, operation codes and command bytes of the line master.
`ifndef LINE_MASTER_MAP_VH
`define LINE_MASTER_MAP_VH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS        100

// ----------------------------------------------------------------------
// Times in microseconds and their cycle counts
// ----------------------------------------------------------------------
// Least time: round up.
`define US_TO_CYC_UP(t) \
   (((t) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reset pulse low time, a least time.
`define RESET_LOW_TIME_US    480
`define RESET_LOW_CYC        `US_TO_CYC_UP(`RESET_LOW_TIME_US)
// Wait after release, covering presence_wait_time plus presence_low_time.
`define RESET_REC_TIME_US    480
`define RESET_REC_CYC        `US_TO_CYC_UP(`RESET_REC_TIME_US)
// Presence sample point after release (inside 60..75 us window).
`define PRESENCE_SAMPLE_US   70
`define PRESENCE_SAMPLE_CYC  `US_TO_CYC_UP(`PRESENCE_SAMPLE_US)
// Write-zero low time.
`define SLOT_LOW0_US         60
`define SLOT_LOW0_CYC        `US_TO_CYC_UP(`SLOT_LOW0_US)
// Write-one and read-start low time.
`define SLOT_LOW1_US         6
`define SLOT_LOW1_CYC        `US_TO_CYC_UP(`SLOT_LOW1_US)
// Read sample point, before the 15 us slave hold ends.
`define SLOT_SAMPLE_US       13
`define SLOT_SAMPLE_CYC      `US_TO_CYC_UP(`SLOT_SAMPLE_US)
// Whole slot including recovery; 75 us gives about 13.3k bits/s.
`define SLOT_TOTAL_US        75
`define SLOT_TOTAL_CYC       `US_TO_CYC_UP(`SLOT_TOTAL_US)

// ----------------------------------------------------------------------
// Operation codes on the command port
// ----------------------------------------------------------------------
`define OP_RESET             2'h0
`define OP_WRITE             2'h1
`define OP_READ              2'h2
`define OP_TRIPLET           2'h3

// ----------------------------------------------------------------------
// Command bytes understood by the slave
// ----------------------------------------------------------------------
`define ROM_CMD_READ_A       8'h33
`define ROM_CMD_READ_B       8'h0f
`define ROM_CMD_MATCH        8'h55
`define ROM_CMD_SKIP         8'hcc
`define ROM_CMD_SEARCH       8'hf0

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define DATA_W               8
`define RSP_FIFO_DEPTH       4
`define CNT_W                13

`endif
